/* File: hdl/htsc_serial_status.v */
// Two-wire serial front end holding the sensor status/configuration register
//
// Operation
// - Status read returns eight bits; status write accepts eight bits.
// - Bit 0 selects 8/12-bit or 12/14-bit resolution; read/write, resets zero.
// - Default widths: temperature 14, humidity 12; reduced to 12 and 8.
// - Bit 6 read-only low-supply flag, no reset, updated after measurement.
// - Low-supply detector flags supply below 2.47 V, accuracy 0.05 V.
// - Bit 2 heater enable, read/write, resets off; one switches heater on.
// - Bit 1 zero means calibration reloads before every measurement.
// - Bit 1 set skips calibration reload, saving about ten milliseconds.
// - Soft reset restores status defaults; next command after 11 ms.
// - Nine or more clocks with data high reset only the interface; ignored during measurement or soft-reset wait.
`timescale 1ns/1ps
`include "htsc_regs.vh"
module htsc_serial_status #(
	parameter SOFT_RST_CYCLES = `HTSC_SOFT_RST_CYC,
	parameter RELOAD_CYCLES = `HTSC_RELOAD_CYC
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Serial pins (data is open drain)
	input wire serial_clk,
	input wire serial_data_in,
	output wire serial_data_out,
	output wire serial_data_oe,
	// Analog supply comparator, high when supply is low
	input wire low_supply_in,
	// Sensor core controls
	output wire heater_en,
	output wire otp_reload,
	output wire conv_start,
	output wire conv_humidity,
	output wire [4:0] conv_bits,
	input wire conv_done
);
	localparam S_IDLE = 9'h001;
	localparam S_START = 9'h002;
	localparam S_CMD = 9'h004;
	localparam S_CACK = 9'h008;
	localparam S_RD = 9'h010;
	localparam S_RACK = 9'h020;
	localparam S_WR = 9'h040;
	localparam S_WACK = 9'h080;
	localparam S_WAIT = 9'h100;

	reg sck_s1_ff, sck_s2_ff, sck_d_ff;
	reg dat_s1_ff, dat_s2_ff, dat_d_ff;
	reg low_s1_ff, low_s2_ff;
	reg [8:0] state_ff;
	reg [3:0] bit_cnt_ff;
	reg [7:0] shift_ff;
	reg drive_low_ff;
	reg [2:0] stat_rw_ff;
	reg [4:0] cmd_ff;
	reg [3:0] toggle_cnt_ff;
	reg [20:0] wait_cnt_ff;
	reg meas_start_ff;
	wire sck_rise, sck_fall, dat_rise, dat_fall;
	wire meas_busy, low_supply_flag;
	wire [7:0] stat_view;
	wire cmd_ok;

	assign sck_rise = sck_s2_ff & ~sck_d_ff;
	assign sck_fall = ~sck_s2_ff & sck_d_ff;
	assign dat_rise = dat_s2_ff & ~dat_d_ff;
	assign dat_fall = ~dat_s2_ff & dat_d_ff;

	// Reserved bits read as zero
	assign stat_view = {1'b0, low_supply_flag, 3'h0, stat_rw_ff};
	assign cmd_ok = (shift_ff[7:5] == `HTSC_ADDR) &&
		((shift_ff[4:0] == `HTSC_CMD_MEAS_T) || (shift_ff[4:0] == `HTSC_CMD_MEAS_RH) ||
		(shift_ff[4:0] == `HTSC_CMD_RD_STAT) || (shift_ff[4:0] == `HTSC_CMD_WR_STAT) ||
		(shift_ff[4:0] == `HTSC_CMD_SOFT_RST));

	// Open drain: only ever pull low
	assign serial_data_out = 1'b0;
	assign serial_data_oe = drive_low_ff;
	assign heater_en = stat_rw_ff[`HTSC_STAT_HEATER_BIT];

	always @(posedge clock) begin
		if (!rst_n) begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_d_ff <= 1'b0;
			dat_s1_ff <= 1'b1;
			dat_s2_ff <= 1'b1;
			dat_d_ff <= 1'b1;
			low_s1_ff <= 1'b0;
			low_s2_ff <= 1'b0;
		end else begin
			sck_s1_ff <= serial_clk;
			sck_s2_ff <= sck_s1_ff;
			sck_d_ff <= sck_s2_ff;
			dat_s1_ff <= serial_data_in;
			dat_s2_ff <= dat_s1_ff;
			dat_d_ff <= dat_s2_ff;
			low_s1_ff <= low_supply_in;
			low_s2_ff <= low_s1_ff;
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= S_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			drive_low_ff <= 1'b0;
			stat_rw_ff <= `HTSC_STAT_RW_RST;
			cmd_ff <= 5'h00;
			toggle_cnt_ff <= 4'h0;
			wait_cnt_ff <= 21'h0;
			meas_start_ff <= 1'b0;
		end else begin
			meas_start_ff <= 1'b0;
			if (sck_rise)
				toggle_cnt_ff <= dat_s2_ff ? ((toggle_cnt_ff == 4'hF) ? 4'hF : toggle_cnt_ff + 4'h1) : 4'h0;
			// interface reset keeps the status register
			if (sck_rise && dat_s2_ff && (toggle_cnt_ff >= `HTSC_CONN_RST_TOGGLES - 4'h1) && !state_ff[8]) begin
				state_ff <= S_IDLE;
				drive_low_ff <= 1'b0;
			end else begin
				case (state_ff)
					S_IDLE: begin
						if (dat_fall && sck_s2_ff)
							state_ff <= S_START;
					end
					S_START: begin
						if (dat_rise && sck_s2_ff) begin
							bit_cnt_ff <= 4'h0;
							state_ff <= S_CMD;
						end
					end
					S_CMD: begin
						if (sck_rise) begin
							shift_ff <= {shift_ff[6:0], dat_s2_ff};
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end else if (sck_fall && bit_cnt_ff == 4'h8) begin
							cmd_ff <= shift_ff[4:0];
							// Unknown command or address: no acknowledge
							if (cmd_ok) begin
								drive_low_ff <= 1'b1;
								state_ff <= S_CACK;
							end else begin
								state_ff <= S_IDLE;
							end
						end
					end
					S_CACK: begin
						if (sck_fall) begin
							drive_low_ff <= 1'b0;
							bit_cnt_ff <= 4'h0;
							case (cmd_ff)
								`HTSC_CMD_RD_STAT: begin
									shift_ff <= {stat_view[6:0], 1'b0};
									drive_low_ff <= ~stat_view[7];
									bit_cnt_ff <= 4'h1;
									state_ff <= S_RD;
								end
								`HTSC_CMD_WR_STAT: begin
									state_ff <= S_WR;
								end
								`HTSC_CMD_SOFT_RST: begin
									stat_rw_ff <= `HTSC_STAT_RW_RST;
									wait_cnt_ff <= SOFT_RST_CYCLES[20:0];
									state_ff <= S_WAIT;
								end
								default: begin
									meas_start_ff <= 1'b1;
									state_ff <= S_WAIT;
								end
							endcase
						end
					end
					S_RD: begin
						// status bits MSB first on falling edges
						if (sck_fall) begin
							if (bit_cnt_ff == 4'h8) begin
								drive_low_ff <= 1'b0;
								state_ff <= S_RACK;
							end else begin
								drive_low_ff <= ~shift_ff[7];
								shift_ff <= {shift_ff[6:0], 1'b0};
								bit_cnt_ff <= bit_cnt_ff + 4'h1;
							end
						end
					end
					S_RACK: begin
						// Host acknowledge is not required; CRC not supported
						if (sck_fall)
							state_ff <= S_IDLE;
					end
					S_WR: begin
						if (sck_rise) begin
							shift_ff <= {shift_ff[6:0], dat_s2_ff};
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end else if (sck_fall && bit_cnt_ff == 4'h8) begin
							// writable bits only; flag and reserved are dropped
							stat_rw_ff <= shift_ff[2:0];
							drive_low_ff <= 1'b1;
							state_ff <= S_WACK;
						end
					end
					S_WACK: begin
						if (sck_fall) begin
							drive_low_ff <= 1'b0;
							state_ff <= S_IDLE;
						end
					end
					S_WAIT: begin
						if (wait_cnt_ff != 21'h0)
							wait_cnt_ff <= wait_cnt_ff - 21'h1;
						else if (!meas_busy && !meas_start_ff)
							state_ff <= S_IDLE;
					end
					default: begin
						state_ff <= S_IDLE;
						drive_low_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	htsc_meas_seq #(
		.RELOAD_CYCLES(RELOAD_CYCLES)
	) u_meas (
		.clock(clock),
		.rst_n(rst_n),
		.start(meas_start_ff),
		.is_humidity(cmd_ff == `HTSC_CMD_MEAS_RH),
		.res_low(stat_rw_ff[`HTSC_STAT_RES_BIT]),
		.no_reload(stat_rw_ff[`HTSC_STAT_NORELOAD_BIT]),
		.busy(meas_busy),
		.conv_done(conv_done),
		.low_supply_sync(low_s2_ff),
		.otp_reload_ff(otp_reload),
		.conv_start_ff(conv_start),
		.conv_humidity_ff(conv_humidity),
		.conv_bits_ff(conv_bits),
		.low_supply_flag_ff(low_supply_flag)
	);
endmodule

/* File: hdl/htsc_regs.vh */
// Status register layout, command codes and timing constants
`ifndef HTSC_REGS_VH
`define HTSC_REGS_VH
`define HTSC_STAT_RES_BIT 0
`define HTSC_STAT_NORELOAD_BIT 1
`define HTSC_STAT_HEATER_BIT 2
`define HTSC_STAT_LOWSUP_BIT 6
`define HTSC_STAT_RW_RST 3'h0
`define HTSC_ADDR 3'h0
`define HTSC_CMD_MEAS_T 5'h03
`define HTSC_CMD_MEAS_RH 5'h05
`define HTSC_CMD_RD_STAT 5'h07
`define HTSC_CMD_WR_STAT 5'h06
`define HTSC_CMD_SOFT_RST 5'h1E
`define HTSC_CLK_PER_MS 125000
`define HTSC_SOFT_RST_MS 11
`define HTSC_RELOAD_MS 10
`define HTSC_SOFT_RST_CYC (`HTSC_SOFT_RST_MS * `HTSC_CLK_PER_MS)
`define HTSC_RELOAD_CYC (`HTSC_RELOAD_MS * `HTSC_CLK_PER_MS)
`define HTSC_CONN_RST_TOGGLES 4'h9
`define HTSC_RH_BITS_HI 5'h0C
`define HTSC_RH_BITS_LO 5'h08
`define HTSC_T_BITS_HI 5'h0E
`define HTSC_T_BITS_LO 5'h0C
`endif

/* File: hdl/htsc_meas_seq.v */
// Measurement sequencer: optional calibration reload, conversion, supply flag capture
`timescale 1ns/1ps
`include "htsc_regs.vh"
module htsc_meas_seq #(
	parameter RELOAD_CYCLES = `HTSC_RELOAD_CYC
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Request from the serial side
	input wire start,
	input wire is_humidity,
	input wire res_low,
	input wire no_reload,
	output wire busy,
	// Converter and calibration store
	input wire conv_done,
	input wire low_supply_sync,
	output reg otp_reload_ff,
	output reg conv_start_ff,
	output reg conv_humidity_ff,
	output reg [4:0] conv_bits_ff,
	output reg low_supply_flag_ff
);
	localparam M_IDLE = 3'h1;
	localparam M_RELOAD = 3'h2;
	localparam M_CONV = 3'h4;

	reg [2:0] state_ff;
	reg [20:0] cnt_ff;

	assign busy = ~state_ff[0];

	always @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= M_IDLE;
			cnt_ff <= 21'h0;
			otp_reload_ff <= 1'b0;
			conv_start_ff <= 1'b0;
			conv_humidity_ff <= 1'b0;
			conv_bits_ff <= `HTSC_T_BITS_HI;
		end else begin
			conv_start_ff <= 1'b0;
			case (state_ff)
				M_IDLE: begin
					if (start) begin
						conv_humidity_ff <= is_humidity;
						if (is_humidity)
							conv_bits_ff <= res_low ? `HTSC_RH_BITS_LO : `HTSC_RH_BITS_HI;
						else
							conv_bits_ff <= res_low ? `HTSC_T_BITS_LO : `HTSC_T_BITS_HI;
						if (no_reload) begin
							conv_start_ff <= 1'b1;
							state_ff <= M_CONV;
						end else begin
							otp_reload_ff <= 1'b1;
							cnt_ff <= RELOAD_CYCLES[20:0];
							state_ff <= M_RELOAD;
						end
					end
				end
				M_RELOAD: begin
					if (cnt_ff <= 21'h1) begin
						otp_reload_ff <= 1'b0;
						conv_start_ff <= 1'b1;
						state_ff <= M_CONV;
					end else begin
						cnt_ff <= cnt_ff - 21'h1;
					end
				end
				M_CONV: begin
					if (conv_done)
						state_ff <= M_IDLE;
				end
				default: begin
					state_ff <= M_IDLE;
				end
			endcase
		end
	end

	// flag has no reset, updated only after a measurement
	// comparator level sampled at conversion end
	always @(posedge clock) begin
		if (state_ff[2] && conv_done)
			low_supply_flag_ff <= low_supply_sync;
	end
endmodule

/* File: verif/htsc_chk_assertions.sv */
// Port checker for the status register front end
`timescale 1ns/1ps
module htsc_chk #(
	parameter SOFT_RST_CYCLES = 50,
	parameter RELOAD_CYCLES = 20
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Link
	input wire serial_clk,
	input wire serial_data_in,
	input wire serial_data_out,
	input wire serial_data_oe,
	// Core
	input wire low_supply_in,
	input wire heater_en,
	input wire otp_reload,
	input wire conv_start,
	input wire conv_humidity,
	input wire [4:0] conv_bits,
	input wire conv_done
);
	reg [20:0] rl_cnt_ff;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Length of the reload run so far
	always @(posedge clock) begin
		if (!rst_n || !otp_reload)
			rl_cnt_ff <= 21'h0;
		else
			rl_cnt_ff <= rl_cnt_ff + 21'h1;
	end
	rst_state_a: assert property (disable iff (1'b0) !rst_n |=> !serial_data_oe && !heater_en
		&& !otp_reload && !conv_start && conv_bits == 5'h0E) else $error("bad reset state");
	out_low_a: assert property (serial_data_out == 1'b0) else $error("data driven high");
	oe_edge_a: assert property ($changed(serial_data_oe) |-> !serial_clk) else $error("data moved");
	heater_edge_a: assert property ($changed(heater_en) |-> !serial_clk) else $error("heater moved");
	bits_t_a: assert property (conv_start && !conv_humidity |-> conv_bits == 5'h0E || conv_bits == 5'h0C)
		else $error("bad temperature width");
	bits_rh_a: assert property (conv_start && conv_humidity |-> conv_bits == 5'h0C || conv_bits == 5'h08)
		else $error("bad humidity width");
	start_once_a: assert property (conv_start |=> !conv_start && !otp_reload) else $error("long start");
	reload_len_a: assert property ($fell(otp_reload) |-> rl_cnt_ff == RELOAD_CYCLES)
		else $error("reload length wrong");
	reload_go_a: assert property ($fell(otp_reload) |-> ##[0:1] conv_start) else $error("no start");
	cover property (otp_reload ##1 !otp_reload);
	cover property (conv_start && conv_humidity);
	cover property ($rose(heater_en));
endmodule

/* File: verif/htsc_host.sv */
// Host model driving the two-wire link
`timescale 1ns/1ps
module htsc_host (
	// Clock
	input wire clock,
	// Link
	input wire serial_data_oe,
	output reg serial_clk,
	output wire serial_data_in
);
	reg hd;
	// Pull-up: a released wire reads high
	assign serial_data_in = serial_data_oe ? 1'b0 : hd;
	initial begin
		serial_clk = 1'b0;
		hd = 1'b1;
	end
	task w(input integer n);
		begin
			repeat (n) @(posedge clock);
			#1;
		end
	endtask
	task sp(input c, input d);
		begin
			serial_clk = c;
			hd = d;
			w(8);
		end
	endtask
	task tstart;
		begin
			sp(1'b0, 1'b1);
			sp(1'b1, 1'b1);
			sp(1'b1, 1'b0);
			sp(1'b0, 1'b0);
			sp(1'b1, 1'b0);
			sp(1'b1, 1'b1);
		end
	endtask
	task xbit(input b, output r);
		begin
			serial_clk = 1'b0;
			w(4);
			hd = b;
			w(4);
			serial_clk = 1'b1;
			w(8);
			r = serial_data_in;
		end
	endtask
	task xfer(input [7:0] d, input hack, output [7:0] q, output ack);
		integer i;
		reg r;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				xbit(d[i], r);
				q[i] = r;
			end
			xbit(hack, r);
			ack = ~r;
			sp(1'b0, 1'b1);
		end
	endtask
	function real linearised_humidity(input integer raw_humidity_count, input lo);
		real v;
		begin
			if (lo)
				v = -2.0468 + 0.5872 * raw_humidity_count - 4.0845e-4 * raw_humidity_count * raw_humidity_count;
			else
				v = -2.0468 + 0.0367 * raw_humidity_count - 1.5955e-6 * raw_humidity_count * raw_humidity_count;
			linearised_humidity = (v > 99.0) ? 100.0 : v;
		end
	endfunction
	function real compensated_humidity(input real t, input integer raw_humidity_count, input lo);
		real t2;
		begin
			t2 = lo ? 0.00128 : 0.00008;
			compensated_humidity = (t - 25.0) * (0.01 + t2 * raw_humidity_count) +
				linearised_humidity(raw_humidity_count, lo);
		end
	endfunction
	function real temp_offset(input integer mv);
		begin
			if (mv >= 5000)
				temp_offset = -40.1;
			else if (mv >= 4000)
				temp_offset = -39.8 - (mv - 4000) * 0.3 / 1000.0;
			else if (mv >= 3500)
				temp_offset = -39.7 - (mv - 3500) * 0.1 / 500.0;
			else if (mv >= 3000)
				temp_offset = -39.6 - (mv - 3000) * 0.1 / 500.0;
			else
				temp_offset = -39.4 - (mv - 2500) * 0.2 / 500.0;
		end
	endfunction
	function real temperature_value(input integer raw_temperature_count, input lo, input integer mv);
		begin
			temperature_value = temp_offset(mv) + (lo ? 0.04 : 0.01) * raw_temperature_count;
		end
	endfunction
	function real dew_point_value(input real rh, input real t);
		real tn, m, g;
		begin
			tn = (t < 0.0) ? 272.62 : 243.12;
			m = (t < 0.0) ? 22.46 : 17.62;
			g = $ln(rh / 100.0) + m * t / (tn + t);
			dew_point_value = tn * g / (m - g);
		end
	endfunction
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the status register front end
`timescale 1ns/1ps
bind htsc_serial_status htsc_chk #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES), .RELOAD_CYCLES(RELOAD_CYCLES)) u_chk (
	.clock(clock), .rst_n(rst_n), .serial_clk(serial_clk), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .low_supply_in(low_supply_in),
	.heater_en(heater_en), .otp_reload(otp_reload), .conv_start(conv_start),
	.conv_humidity(conv_humidity), .conv_bits(conv_bits), .conv_done(conv_done));
module tb;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg low_supply_in = 1'b0;
	reg conv_done = 1'b0;
	wire serial_clk, serial_data_in, serial_data_out, serial_data_oe;
	wire heater_en, otp_reload, conv_start, conv_humidity;
	wire [4:0] conv_bits;
	integer error_cnt = 0;
	integer num_checks = 0;
	integer rl_n = 0;
	integer cs_n = 0;
	reg [7:0] q;
	reg a;
	initial begin
		forever #4 clock = ~clock;
	end
	// Converter answers one cycle after start
	always @(posedge clock) begin
		conv_done <= #1 conv_start;
		rl_n <= rl_n + (otp_reload === 1'b1);
		cs_n <= cs_n + (conv_start === 1'b1);
	end
	htsc_serial_status #(.SOFT_RST_CYCLES(50), .RELOAD_CYCLES(20)) u_dut (
		.clock(clock), .rst_n(rst_n), .serial_clk(serial_clk), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .low_supply_in(low_supply_in),
		.heater_en(heater_en), .otp_reload(otp_reload), .conv_start(conv_start),
		.conv_humidity(conv_humidity), .conv_bits(conv_bits), .conv_done(conv_done));
	htsc_host u_host (.clock(clock), .serial_data_oe(serial_data_oe), .serial_clk(serial_clk),
		.serial_data_in(serial_data_in));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task cmd(input [7:0] c, input e);
		begin
			u_host.tstart;
			u_host.xfer(c, 1'b1, q, a);
			chk({7'h0, a}, {7'h0, e});
		end
	endtask
	task rd(input [7:0] m, input [7:0] e);
		begin
			cmd(8'h07, 1'b1);
			u_host.xfer(8'hFF, 1'b0, q, a);
			chk(q & m, e & m);
		end
	endtask
	task wr(input [7:0] d);
		begin
			cmd(8'h06, 1'b1);
			u_host.xfer(d, 1'b1, q, a);
			chk({7'h0, a}, 8'h01);
		end
	endtask
	task meas(input [7:0] c, input [4:0] b, input h, input [7:0] r);
		integer i, n0, r0;
		begin
			n0 = cs_n;
			r0 = rl_n;
			cmd(c, 1'b1);
			for (i = 0; i < 300 && cs_n == n0; i = i + 1)
				u_host.w(1);
			if (cs_n == n0) begin
				chk(8'h00, 8'h01);
				report_and_stop;
			end
			chk({3'h0, conv_bits}, {3'h0, b});
			chk({7'h0, conv_humidity}, {7'h0, h});
			chk(8'(rl_n - r0), r);
			u_host.w(4);
		end
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#1 rst_n = 1'b1;
		chk({3'h0, conv_bits}, 8'h0E);
		chk({7'h0, heater_en}, 8'h00);
		rd(8'hBF, 8'h00);
		cmd(8'h20, 1'b0);
		wr(8'h07);
		chk({7'h0, heater_en}, 8'h01);
		rd(8'hBF, 8'h07);
		low_supply_in = 1'b1;
		meas(8'h03, 5'h0C, 1'b0, 8'h00);
		meas(8'h05, 5'h08, 1'b1, 8'h00);
		rd(8'hFF, 8'h47);
		wr(8'h00);
		low_supply_in = 1'b0;
		meas(8'h05, 5'h0C, 1'b1, 8'h14);
		meas(8'h03, 5'h0E, 1'b0, 8'h14);
		rd(8'hFF, 8'h00);
		wr(8'h05);
		repeat (10) u_host.xbit(1'b1, a);
		rd(8'hBF, 8'h05);
		cmd(8'h1E, 1'b1);
		repeat (60) @(posedge clock);
		rd(8'hBF, 8'h00);
		chk({7'h0, heater_en}, 8'h00);
		// Host-side conversions of raw counts, and dew point from humidity and temperature
		chk(8'($rtoi(u_host.linearised_humidity(1073, 1'b0))), 8'h23);
		chk(8'($rtoi(u_host.linearised_humidity(100, 1'b1))), 8'h34);
		chk(8'($rtoi(u_host.linearised_humidity(4095, 1'b0))), 8'h64);
		chk(8'($rtoi(u_host.compensated_humidity(45.0, 1073, 1'b0))), 8'h25);
		chk(8'($rtoi(u_host.compensated_humidity(45.0, 100, 1'b1))), 8'h37);
		chk(8'($rtoi(u_host.temperature_value(2000, 1'b1, 2500))), 8'h28);
		chk(8'($rtoi(u_host.temperature_value(4000, 1'b0, 3250) * 100.0 + 0.5)), 8'h23);
		chk(8'($rtoi(u_host.dew_point_value(50.0, 20.0))), 8'h09);
		chk(8'($rtoi(-u_host.dew_point_value(80.0, -10.0))), 8'h0C);
		report_and_stop;
	end
endmodule
